// >>> pkg/dac_cap_map.svh
// Offsets, field positions and reset values of the code cap register bank
`ifndef DAC_CAP_MAP_SVH
`define DAC_CAP_MAP_SVH

// Register indices; byte address is four times the index
`define CAP_IDX        10'h04d
`define ACT_IDX        10'h050
`define HIT_IDX        10'h051

// Cap register field layout
`define A2_CAP_LSB     0
`define A2_CAP_MSB     5
`define A3_CAP_LSB     8
`define A3_CAP_MSB     13

// Reset values
`define CAP_RESET      6'h3f
`define CAP_REG_RESET  16'h3f3f
`define ACT_RESET      16'h0000

// Ceiling shape: cap sits above seven low bits forced to one
`define CEIL_SHIFT     7
`define CEIL_LOW_ONES  7'h7f

`endif

// >>> pkg/dac_cap_pkg.sv
// Types and the ceiling function shared by the code cap block
package dac_cap_pkg;

	typedef logic [5:0]  cap_t;   // Six-bit cap field
	typedef logic [15:0] code_t;  // DAC code as latched

	// Whole state of the register bank
	typedef struct packed {
		cap_t        cap_a2;  // Channel A2 cap
		cap_t        cap_a3;  // Channel A3 cap
		code_t       act_a2;  // Channel A2 active code
		code_t       act_a3;  // Channel A3 active code
		logic [1:0]  hit;     // Sticky clamp flags
		logic        ack;     // Bus acknowledge
		logic [31:0] rdata;   // Bus read data
	} state_t;

	// Cap value to code ceiling: cap * 80h + 7Fh
	function automatic code_t ceiling(input cap_t cap);
		ceiling = {3'h0, cap, 7'h7f};
	endfunction

endpackage

// >>> rtl/code_clamp.sv
// Clamp of one channel's incoming code against its cap ceiling
`timescale 1ns/1ps
module code_clamp (
	input  wire logic [5:0]  i_cap,      // Cap field of the channel
	input  wire logic [15:0] i_code,     // Code headed for active reg
	output logic      [15:0] o_ceiling,  // Ceiling from the cap
	output logic      [15:0] o_code,     // Code after clamping
	output logic             o_over      // Code was above ceiling
);

	// Ceiling: cap in bits 12-7, three MSBs zero, seven low bits all ones
	always_comb begin
		o_ceiling = dac_cap_pkg::ceiling(i_cap);
		o_over    = (i_code > o_ceiling);
		// Clamp rather than drop, so the channel still moves
		if (o_over) begin
			o_code = o_ceiling;
		end else begin
			o_code = i_code;
		end
	end

endmodule

// >>> rtl/dac_code_cap_a2_a3.sv
// Code cap register for group A channels 2 and 3, Wishbone slave
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "dac_cap_map.svh"
module dac_code_cap_a2_a3 (
	input  wire logic        i_core_clk,     // Core clock, 20 MHz
	input  wire logic        i_rst,          // Sync reset, active high
	input  wire logic        i_ce,           // Clock enable
	input  wire logic        i_wb_cyc,       // Bus cycle
	input  wire logic        i_wb_stb,       // Bus strobe
	input  wire logic        i_wb_we,        // Write enable
	input  wire logic [11:0] i_wb_adr,       // Byte address
	input  wire logic [3:0]  i_wb_sel,       // Byte enables
	input  wire logic [31:0] i_wb_dat,       // Write data
	output logic             o_wb_ack,       // Acknowledge
	output logic      [31:0] o_wb_dat,       // Read data
	input  wire logic        i_a2_load,      // Latch strobe, channel A2
	input  wire logic [15:0] i_a2_code,      // New code, channel A2
	input  wire logic        i_a3_load,      // Latch strobe, channel A3
	input  wire logic [15:0] i_a3_code,      // New code, channel A3
	output logic      [15:0] o_a2_active,    // Active code, channel A2
	output logic      [15:0] o_a3_active,    // Active code, channel A3
	output logic      [1:0]  o_clamp_hit     // Sticky clamp flags
);

	// Decoded register selection
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_CAP  = 2'h1;
	localparam logic [1:0] SEL_ACT  = 2'h2;
	localparam logic [1:0] SEL_HIT  = 2'h3;

	dac_cap_pkg::state_t r;   // Registered state
	dac_cap_pkg::state_t n;   // Next state

	logic [15:0] a2_ceil;     // Channel A2 ceiling
	logic [15:0] a2_clamped;  // Channel A2 code after clamp
	logic        a2_over;     // Channel A2 code above ceiling
	logic [15:0] a3_ceil;     // Channel A3 ceiling
	logic [15:0] a3_clamped;  // Channel A3 code after clamp
	logic        a3_over;     // Channel A3 code above ceiling
	logic        req;         // New bus request this cycle
	logic [1:0]  sel;         // Register hit by the request

	// Address decode; two low address bits ignored, word access only
	function automatic logic [1:0] reg_sel(input logic [11:0] a);
		if (a[11:2] == `CAP_IDX) begin
			reg_sel = SEL_CAP;
		end else if (a[11:2] == `ACT_IDX) begin
			reg_sel = SEL_ACT;
		end else if (a[11:2] == `HIT_IDX) begin
			reg_sel = SEL_HIT;
		end else begin
			reg_sel = SEL_NONE;
		end
	endfunction

	// Clamp of channel A2 against its own cap
	code_clamp u_a2_clamp (
		.i_cap     (r.cap_a2),
		.i_code    (i_a2_code),
		.o_ceiling (a2_ceil),
		.o_code    (a2_clamped),
		.o_over    (a2_over)
	);

	// Clamp of channel A3 against its own cap
	code_clamp u_a3_clamp (
		.i_cap     (r.cap_a3),
		.i_code    (i_a3_code),
		.o_ceiling (a3_ceil),
		.o_code    (a3_clamped),
		.o_over    (a3_over)
	);

	// Request seen once; ack high in the next cycle keeps it single-shot
	assign req = i_wb_cyc && i_wb_stb && !r.ack;
	assign sel = reg_sel(i_wb_adr);

	// Next state: bus access, code latching and clamp flags
	always_comb begin
		n       = r;
		n.ack   = req;
		n.rdata = 32'h0;
		// Read mux; reserved bits and unmapped words read zero
		if (req && !i_wb_we) begin
			case (sel)
				SEL_CAP: begin
					n.rdata = {16'h0, 2'h0, r.cap_a3,
						2'h0, r.cap_a2};
				end
				SEL_ACT: begin
					n.rdata = {r.act_a3, r.act_a2};
				end
				SEL_HIT: begin
					n.rdata = {30'h0, r.hit};
				end
				default: begin
					n.rdata = 32'h0;
				end
			endcase
		end
		// Cap writes, one byte lane per channel field
		if (req && i_wb_we && sel == SEL_CAP) begin
			if (i_wb_sel[0]) begin
				n.cap_a2 = i_wb_dat[`A2_CAP_MSB:`A2_CAP_LSB];
			end
			if (i_wb_sel[1]) begin
				n.cap_a3 = i_wb_dat[`A3_CAP_MSB:`A3_CAP_LSB];
			end
		end
		// Clamp flags: write one to clear
		if (req && i_wb_we && sel == SEL_HIT && i_wb_sel[0]) begin
			n.hit = r.hit & ~i_wb_dat[1:0];
		end
		// Latching uses the cap in force before any same-cycle write
		if (i_a2_load) begin
			n.act_a2 = a2_clamped;
			if (a2_over) begin
				n.hit[0] = 1'b1;  // Set wins over a clear
			end
		end
		if (i_a3_load) begin
			n.act_a3 = a3_clamped;
			if (a3_over) begin
				n.hit[1] = 1'b1;  // Set wins over a clear
			end
		end
	end

	// State register; enable low freezes everything, bus included
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			r.cap_a2 <= `CAP_RESET;
			r.cap_a3 <= `CAP_RESET;
			r.act_a2 <= `ACT_RESET;
			r.act_a3 <= `ACT_RESET;
			r.hit    <= 2'h0;
			r.ack    <= 1'b0;
			r.rdata  <= 32'h0;
		end else if (i_ce) begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign o_wb_ack    = r.ack;
	assign o_wb_dat    = r.rdata;
	assign o_a2_active = r.act_a2;
	assign o_a3_active = r.act_a3;
	assign o_clamp_hit = r.hit;

	// Checks on the bank's own behaviour
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	// A fresh bus request in an enabled cycle
	sequence s_req;
		i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence

	// Write to the cap register
	sequence s_cap_wr;
		s_req and (i_wb_we && reg_sel(i_wb_adr) == SEL_CAP);
	endsequence

	// Read of the cap register
	sequence s_cap_rd;
		s_req and (!i_wb_we && reg_sel(i_wb_adr) == SEL_CAP);
	endsequence

	// Channel A2 load of a code above its ceiling
	sequence s_a2_over;
		i_ce && i_a2_load && (i_a2_code > a2_ceil);
	endsequence

	a_ack_one_cycle: assert property (
		s_req |=> o_wb_ack ##1 (!o_wb_ack || !i_ce))
		else $error("ack not a single cycle after request");

	a_cap_reset_val: assert property (
		$fell(i_rst) |-> (r.cap_a2 == 6'h3f && r.cap_a3 == 6'h3f))
		else $error("cap fields not 3F after reset");

	a_cap_write_a2: assert property (
		s_cap_wr and i_wb_sel[0] |=> r.cap_a2 == $past(i_wb_dat[5:0]))
		else $error("A2 cap not written from bits 5-0");

	a_cap_write_a3: assert property (
		s_cap_wr and i_wb_sel[1] |=> r.cap_a3 == $past(i_wb_dat[13:8]))
		else $error("A3 cap not written from bits 13-8");

	a_cap_readback: assert property (
		s_cap_rd |=> o_wb_ack && o_wb_dat[31:14] == 18'h0
			&& o_wb_dat[7:6] == 2'h0
			&& o_wb_dat[13:8] == r.cap_a3 && o_wb_dat[5:0] == r.cap_a2)
		else $error("cap register read back wrong");

	a_ceiling_map: assert property (
		a3_ceil == ((16'(r.cap_a3) * 16'h0080) + 16'h007f))
		else $error("A3 ceiling not cap times 80h plus 7Fh");

	a_low_ones: assert property (
		a2_ceil[6:0] == 7'h7f && a2_ceil[15:13] == 3'h0)
		else $error("A2 ceiling low bits not all ones");

	a_a2_clamped: assert property (
		s_a2_over |=> o_a2_active == $past(a2_ceil) && o_clamp_hit[0])
		else $error("A2 code above ceiling not clamped");

	a_a3_latched: assert property (
		i_ce && i_a3_load |=> o_a3_active == (($past(i_a3_code)
			> $past(a3_ceil)) ? $past(a3_ceil) : $past(i_a3_code)))
		else $error("A3 active code not min of code and ceiling");

endmodule

// >>> dv/dac_code_cap_a2_a3_bench.sv
// Self-checking bench for the group A ch2/ch3 code cap register
`timescale 1ns/1ps
module dac_code_cap_a2_a3_bench;
	logic        clk;         // Core clock, 20 MHz
	logic        rst;         // Sync reset
	logic        cyc;         // Bus cycle and strobe
	logic        we;          // Bus direction
	logic [11:0] adr;         // Byte address
	logic [3:0]  sel;         // Lanes
	logic [31:0] wd;          // Write data
	logic        ack;         // Slave answer
	logic [31:0] rd;          // Read data
	logic        ld;          // Load strobe, both channels
	logic [15:0] c2;          // Code for A2
	logic [15:0] c3;          // Code for A3
	logic [15:0] act2;        // Active A2
	logic [15:0] act3;        // Active A3
	logic [1:0]  hit;         // Clamp flags
	logic [1:0]  ehit;        // Expected flags
	logic [5:0]  cap2;        // Expected A2 cap
	logic [5:0]  cap3;        // Expected A3 cap
	logic [15:0] lf;          // LFSR state
	logic [31:0] q;           // Last read
	int          mismatches;  // Failed compares
	int          n_checks;    // All compares
	int          cyc_n;       // Timeout count

	dac_code_cap_a2_a3 dut (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1),
		.i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wd), .o_wb_ack(ack), .o_wb_dat(rd),
		.i_a2_load(ld), .i_a2_code(c2), .i_a3_load(ld), .i_a3_code(c3),
		.o_a2_active(act2), .o_a3_active(act3), .o_clamp_hit(hit));

	// Clock: 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Hang guard, far above the expected run
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	function logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Ceiling worked out independently: cap * 80h + 7Fh
	function logic [15:0] ceil_of(input logic [5:0] p);
		return {10'h000, p} * 16'h0080 + 16'h007f;
	endfunction

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Classic cycle; also drops the load strobe so caps never race it
	task wb(input logic w, input logic [11:0] a, input logic [3:0] s,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		ld <= 1'b0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rd;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask

	// Strobe stays high, so loads run back to back
	task load(input logic [15:0] a, input logic [15:0] b);
		@(posedge clk);
		ld <= 1'b1;
		c2 <= a;
		c3 <= b;
		@(negedge clk);
		@(negedge clk);
		if (a > ceil_of(cap2)) ehit[0] = 1'b1;
		if (b > ceil_of(cap3)) ehit[1] = 1'b1;
		check(act2, (a > ceil_of(cap2)) ? ceil_of(cap2) : a);
		check(act3, (b > ceil_of(cap3)) ? ceil_of(cap3) : b);
		check(hit, ehit);
	endtask

	task end_of_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		{rst, cyc, we, ld, adr, sel, wd, c2, c3, ehit} = '0;
		rst = 1'b1;
		cap2 = 6'h3f;
		cap3 = 6'h3f;
		lf = 16'h000b;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, 12'h134, 4'hf, 32'h0);
		check(q, 32'h00003f3f);
		$display("test reset done");
		// Corners first (caps 00 and 1F), then random lanes and codes
		for (int i = 0; i < 30; i++) begin
			lf = lfsr(lf);
			sel = (i < 2) ? 4'h3 : lf[3:0];
			wd = (i == 0) ? 32'h0 : (i == 1) ? 32'h1f1f : {lf, ~lf};
			if (sel[0]) cap2 = wd[5:0];
			if (sel[1]) cap3 = wd[13:8];
			wb(1'b1, 12'h134, sel, wd);
			wb(1'b0, 12'h134, 4'hf, 32'h0);
			check(q, {18'h0, cap3, 2'h0, cap2});
			lf = lfsr(lf);
			load(lf, ~lf);
			load(ceil_of(cap2), ceil_of(cap3) + 16'h0001);
		end
		$display("test caps and clamps done");
		// Read-only and unmapped places, then flag clear
		wb(1'b1, 12'h140, 4'hf, 32'hffffffff);
		wb(1'b0, 12'h140, 4'hf, 32'h0);
		check(q[15:0], ceil_of(cap2));
		wb(1'b0, 12'h200, 4'hf, 32'h0);
		check(q, 32'h0);
		wb(1'b1, 12'h144, 4'h1, 32'h3);
		wb(1'b0, 12'h144, 4'hf, 32'h0);
		check(q, 32'h0);
		$display("test map done");
		end_of_test();
	end
endmodule
